// ===== clpr_reg_bank.sv
/*
  Register bank of the CAN-linked 16-pin port, with event capture and the
  reply scheduling toward the CAN frame engine.
  Assumes the frame engine delivers checked frames as one-cycle pulses and
  marks the end of each sent Control Field with a pulse.

// What this block does
// RULE1: Write frame: byte one is the address, bytes two and three the value.
// RULE2: Writes to read-only registers are dropped; register stays unchanged.
// RULE3: Address 0 mirrors all sixteen pins; sent on poll or capture edge.
// RULE4: Pins sampled into transmit buffer only after Control Field is sent.
// RULE5: Pin changes before transmission overwrite the matching buffered bit.
// RULE6: Input state sent automatically in sign-on after calibration.
// RULE7: Rise enable bits at address 1 enable rising edge capture.
// RULE8: Fall enable bits at address 2 enable falling edge capture.
// RULE9: Both enable bits set capture both edge directions.
// RULE10: Output value drives pins only once its frame is checked valid.
// RULE11: Driver enable bit 1 drives the pin, 0 leaves it floating.
// RULE12: Driver enable alone makes output; polling always; capture by edge bits.
// RULE13: Analog setup: start 15, comparators 14-12, zero 11, mux 10-8, switch 7-5.
// RULE14: Conversion result holds ten bits, other bits read zero.
// RULE15: Analog setup controls analog pins; results read via conversion register.
// RULE16: Pulse-density registers hold ten bits at 15 to 6, low bits zero.
// RULE17: Remote Frame poll answered with input state Data Frame.
// RULE18: Every Data Frame answered with status, address and register contents.
*/
`default_nettype none
module clpr_reg_bank
  import clpr_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Received frames from the CAN engine
  input wire logic I_RX_DATA_VALID,
  input wire logic [7:0] I_RX_BYTE1,
  input wire logic [7:0] I_RX_BYTE2,
  input wire logic [7:0] I_RX_BYTE3,
  input wire logic I_RX_REMOTE_VALID,
  input wire logic I_CALIBRATED,
  input wire logic [3:0] I_STATUS,
  // Transmit side of the CAN engine
  output logic O_TX_REQ,
  input wire logic I_TX_CTRL_DONE,
  input wire logic I_TX_DONE,
  output logic [3:0] O_TX_STATUS,
  output logic [7:0] O_TX_ADDR,
  output logic [15:0] O_TX_DATA,
  // Port pins
  input wire logic [15:0] I_PIN,
  output logic [15:0] O_PIN,
  output logic [15:0] O_PIN_OE,
  // Analog front end
  input wire logic [2:0] I_CMP_OUT,
  input wire logic I_CONV_DONE,
  input wire logic [9:0] I_CONV_RESULT,
  output logic O_CONV_START,
  output logic [2:0] O_MUX_SEL,
  output logic [2:0] O_SWITCH_SEL,
  output logic [9:0] O_PULSE_DENSITY_ONE,
  output logic [9:0] O_PULSE_DENSITY_TWO
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] rise_capture_enable;
  logic [15:0] fall_capture_enable;
  logic [15:0] port_output_value;
  logic [15:0] driver_enable;
  logic [2:0] mux_sel;
  logic [2:0] switch_sel;
  logic [9:0] pulse_density_one;
  logic [9:0] pulse_density_two;
  logic [9:0] conversion_result;
  logic conv_busy;
  logic [15:0] pin_level;
  logic edge_event;
  logic cal_prev;
  logic [2:0] cmp_sync1;
  logic [2:0] cmp_sync2;

  // Pending replies
  logic echo_pend;
  logic [7:0] echo_addr;
  logic input_pend;
  logic conv_pend;
  logic tx_busy;
  logic tx_sampling;
  logic ctrl_sent;
  clpr_tx_kind_t tx_kind;

  logic [15:0] wr_value;
  assign wr_value = {I_RX_BYTE2, I_RX_BYTE3}; // [RULE1]

  clpr_edge_detect u_edge (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_pin(I_PIN),
    .i_rise_en(rise_capture_enable),
    .i_fall_en(fall_capture_enable),
    .o_level(pin_level),
    .o_event(edge_event)
  );

  // ----------------------------------------------------------------
  // Comparator levels, asynchronous to the clock
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cmp_sync1 <= 3'h0;
      cmp_sync2 <= 3'h0;
    end else begin
      cmp_sync1 <= I_CMP_OUT;
      cmp_sync2 <= cmp_sync1;
    end
  end

  // ----------------------------------------------------------------
  // Read-back of any register
  // ----------------------------------------------------------------
  function automatic logic [15:0] read_reg(input logic [7:0] addr);
    logic [15:0] v;
    v = 16'h0000;
    case (addr)
      ADDR_PORT_INPUT_STATE: v = pin_level; // [RULE3]
      ADDR_RISE_CAPTURE_ENABLE: v = rise_capture_enable;
      ADDR_FALL_CAPTURE_ENABLE: v = fall_capture_enable;
      ADDR_PORT_OUTPUT_VALUE: v = port_output_value;
      ADDR_DRIVER_ENABLE: v = driver_enable;
      ADDR_ANALOG_SETUP: begin // [RULE13]
        v[AS_START_BIT] = conv_busy;
        v[AS_CMP_HI:AS_CMP_LO] = cmp_sync2;
        v[AS_MUX_HI:AS_MUX_LO] = mux_sel;
        v[AS_SW_HI:AS_SW_LO] = switch_sel;
      end
      ADDR_PULSE_DENSITY_ONE: v[PD_HI:PD_LO] = pulse_density_one; // [RULE16]
      ADDR_PULSE_DENSITY_TWO: v[PD_HI:PD_LO] = pulse_density_two; // [RULE16]
      ADDR_CONVERSION_RESULT: v[CR_WIDTH-1:0] = conversion_result; // [RULE14] [RULE15]
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Register writes, only on a checked frame
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      rise_capture_enable <= RST_REG;
      fall_capture_enable <= RST_REG;
      port_output_value <= RST_REG;
      driver_enable <= RST_REG;
      mux_sel <= 3'h0;
      switch_sel <= 3'h0;
      pulse_density_one <= 10'h000;
      pulse_density_two <= 10'h000;
    end else if (I_RX_DATA_VALID) begin
      // Address 0 and 8 are read-only: value dropped
      case (I_RX_BYTE1) // [RULE2]
        ADDR_RISE_CAPTURE_ENABLE: rise_capture_enable <= wr_value; // [RULE7]
        ADDR_FALL_CAPTURE_ENABLE: fall_capture_enable <= wr_value; // [RULE8]
        ADDR_PORT_OUTPUT_VALUE: port_output_value <= wr_value; // [RULE10]
        ADDR_DRIVER_ENABLE: driver_enable <= wr_value; // [RULE11]
        ADDR_ANALOG_SETUP: begin // [RULE15]
          mux_sel <= wr_value[AS_MUX_HI:AS_MUX_LO];
          switch_sel <= wr_value[AS_SW_HI:AS_SW_LO];
        end
        ADDR_PULSE_DENSITY_ONE: pulse_density_one <= wr_value[PD_HI:PD_LO];
        ADDR_PULSE_DENSITY_TWO: pulse_density_two <= wr_value[PD_HI:PD_LO];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Conversion start and result
  // ----------------------------------------------------------------
  logic conv_trigger;
  assign conv_trigger = I_RX_DATA_VALID && !conv_busy &&
    ((I_RX_BYTE1 == ADDR_ANALOG_SETUP && wr_value[AS_START_BIT]) ||
     I_RX_BYTE1 == ADDR_CONVERSION_RESULT);

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      conv_busy <= 1'b0;
      conversion_result <= 10'h000;
    end else begin
      if (conv_trigger) begin
        conv_busy <= 1'b1;
      end else if (I_CONV_DONE) begin
        conv_busy <= 1'b0;
      end
      if (I_CONV_DONE) begin
        conversion_result <= I_CONV_RESULT;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CONV_START <= 1'b0;
    end else begin
      O_CONV_START <= conv_trigger;
    end
  end

  // ----------------------------------------------------------------
  // Pending reply flags; a new set wins over the clear
  // ----------------------------------------------------------------
  logic start_tx;
  logic pick_echo;
  logic pick_input;
  logic pick_conv;
  assign start_tx = !tx_busy && (echo_pend || input_pend || conv_pend);
  assign pick_conv = start_tx && conv_pend;
  assign pick_echo = start_tx && !conv_pend && echo_pend;
  assign pick_input = start_tx && !conv_pend && !echo_pend;

  // Echo of every checked Data Frame; latest address wins
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      echo_pend <= 1'b0;
      echo_addr <= 8'h00;
    end else begin
      if (I_RX_DATA_VALID) begin
        echo_pend <= 1'b1; // [RULE18]
        echo_addr <= I_RX_BYTE1;
      end else if (pick_echo) begin
        echo_pend <= 1'b0;
      end
    end
  end

  // Input state on poll, capture edge or sign-on
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      input_pend <= 1'b0;
      cal_prev <= 1'b0;
    end else begin
      cal_prev <= I_CALIBRATED;
      if (I_RX_REMOTE_VALID || edge_event || (I_CALIBRATED && !cal_prev)) begin
        input_pend <= 1'b1; // [RULE17] [RULE3] [RULE6] [RULE12]
      end else if (pick_input) begin
        input_pend <= 1'b0;
      end
    end
  end

  // Result of a finished conversion
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      conv_pend <= 1'b0;
    end else begin
      if (I_CONV_DONE && conv_busy) begin
        conv_pend <= 1'b1; // [RULE15]
      end else if (pick_conv) begin
        conv_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply control
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_busy <= 1'b0;
      tx_sampling <= 1'b0;
      ctrl_sent <= 1'b0;
      tx_kind <= CLPR_TX_ECHO;
    end else if (start_tx) begin
      tx_busy <= 1'b1;
      ctrl_sent <= 1'b0;
      if (pick_conv) begin
        tx_kind <= CLPR_TX_CONV;
        tx_sampling <= 1'b0;
      end else if (pick_echo) begin
        tx_kind <= CLPR_TX_ECHO;
        tx_sampling <= (echo_addr == ADDR_PORT_INPUT_STATE);
      end else begin
        tx_kind <= CLPR_TX_INPUT;
        tx_sampling <= 1'b1;
      end
    end else if (tx_busy) begin
      if (I_TX_DONE) begin
        tx_busy <= 1'b0;
        tx_sampling <= 1'b0;
        ctrl_sent <= 1'b0;
      end else if (I_TX_CTRL_DONE) begin
        ctrl_sent <= 1'b1; // [RULE4]
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  logic sample_pins;
  assign sample_pins = tx_busy && !I_TX_DONE && tx_sampling &&
    tx_kind != CLPR_TX_CONV && (ctrl_sent || I_TX_CTRL_DONE);

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TX_STATUS <= STATUS_NONE;
      O_TX_ADDR <= 8'h00;
      O_TX_DATA <= RST_REG;
    end else if (start_tx) begin
      O_TX_STATUS <= I_STATUS; // [RULE18]
      if (pick_conv) begin
        O_TX_ADDR <= ADDR_CONVERSION_RESULT;
        O_TX_DATA <= read_reg(ADDR_CONVERSION_RESULT);
      end else if (pick_echo) begin
        O_TX_ADDR <= echo_addr;
        O_TX_DATA <= read_reg(echo_addr); // [RULE18]
      end else begin
        O_TX_ADDR <= ADDR_PORT_INPUT_STATE;
        O_TX_DATA <= RST_REG;
      end
    end else if (sample_pins) begin
      // Pins settled after the Control Field; later changes overwrite bits
      O_TX_DATA <= pin_level; // [RULE4] [RULE5]
    end
  end

  assign O_TX_REQ = tx_busy;

  // ----------------------------------------------------------------
  // Pin drivers and analog outputs
  // ----------------------------------------------------------------
  assign O_PIN = port_output_value; // [RULE10]
  assign O_PIN_OE = driver_enable; // [RULE11] [RULE12]
  assign O_MUX_SEL = mux_sel;
  assign O_SWITCH_SEL = switch_sel;
  assign O_PULSE_DENSITY_ONE = pulse_density_one;
  assign O_PULSE_DENSITY_TWO = pulse_density_two;
endmodule
`default_nettype wire

// ===== clpr_pkg.sv
/*
  Package for the CAN-linked port register bank: addresses, field layouts,
  reset values and enumerations.
  Assumes a 16-pin port and a CAN frame engine outside this block.
*/
`default_nettype none
package clpr_pkg;
  // ----------------------------------------------------------------
  // Register addresses (first data byte of a write frame)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_INPUT_STATE = 8'h00;
  localparam logic [7:0] ADDR_RISE_CAPTURE_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_FALL_CAPTURE_ENABLE = 8'h02;
  localparam logic [7:0] ADDR_PORT_OUTPUT_VALUE = 8'h03;
  localparam logic [7:0] ADDR_DRIVER_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_ANALOG_SETUP = 8'h05;
  localparam logic [7:0] ADDR_PULSE_DENSITY_ONE = 8'h06;
  localparam logic [7:0] ADDR_PULSE_DENSITY_TWO = 8'h07;
  localparam logic [7:0] ADDR_CONVERSION_RESULT = 8'h08;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int PORT_WIDTH = 16;
  localparam int AS_START_BIT = 15;
  localparam int AS_CMP_HI = 14;
  localparam int AS_CMP_LO = 12;
  localparam int AS_MUX_HI = 10;
  localparam int AS_MUX_LO = 8;
  localparam int AS_SW_HI = 7;
  localparam int AS_SW_LO = 5;
  localparam int PD_HI = 15;
  localparam int PD_LO = 6;
  localparam int CR_WIDTH = 10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [3:0] STATUS_NONE = 4'h0;

  // ----------------------------------------------------------------
  // Reply kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLPR_TX_ECHO,
    CLPR_TX_INPUT,
    CLPR_TX_CONV
  } clpr_tx_kind_t;
endpackage
`default_nettype wire

// ===== clpr_edge_detect.sv
/*
  Edge detector for the port pins: synchronises the pins and flags any
  enabled rising or falling edge.
  Assumes pins are asynchronous to the clock.
*/
`default_nettype none
module clpr_edge_detect
  import clpr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins and enables
  input wire logic [15:0] i_pin,
  input wire logic [15:0] i_rise_en,
  input wire logic [15:0] i_fall_en,
  // Results
  output logic [15:0] o_level,
  output logic o_event
);
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [15:0] prev;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= RST_REG;
      sync2 <= RST_REG;
      prev <= RST_REG;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign o_level = sync2;
  // Rising, falling, or both per pin
  assign o_event = |((sync2 & ~prev & i_rise_en) | (~sync2 & prev & i_fall_en)); // [RULE7] [RULE8] [RULE9]
endmodule
`default_nettype wire

// ===== clpr_asserts.sv
/*
  Checker for the CAN-linked port register bank.
  Assumes it is bound to the bank and sees only the bank's ports.
*/
`default_nettype none
module clpr_asserts
  import clpr_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Frames and replies
  input wire logic I_RX_DATA_VALID,
  input wire logic [7:0] I_RX_BYTE1,
  input wire logic [7:0] I_RX_BYTE2,
  input wire logic [7:0] I_RX_BYTE3,
  input wire logic I_RX_REMOTE_VALID,
  input wire logic O_TX_REQ,
  input wire logic I_TX_DONE,
  input wire logic [7:0] O_TX_ADDR,
  // Port and analog outputs
  input wire logic [15:0] O_PIN,
  input wire logic [15:0] O_PIN_OE,
  input wire logic [2:0] O_MUX_SEL,
  input wire logic [9:0] O_PULSE_DENSITY_ONE
);
  wire logic [15:0] val = {I_RX_BYTE2, I_RX_BYTE3};
  wire logic [9:0] pd_val = val[15:6];
  wire logic [2:0] mux_val = val[10:8];
  wire logic wr_pin = I_RX_DATA_VALID && I_RX_BYTE1 == ADDR_PORT_OUTPUT_VALUE;
  wire logic wr_oe = I_RX_DATA_VALID && I_RX_BYTE1 == ADDR_DRIVER_ENABLE;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  a_reply_start: assert property (I_RX_DATA_VALID && !O_TX_REQ |-> ##[1:2] O_TX_REQ)
    else $error("reply not started");
  a_reply_hold: assert property (O_TX_REQ && !I_TX_DONE |=> O_TX_REQ && $stable(O_TX_ADDR))
    else $error("reply not held");
  a_reply_drop: assert property (O_TX_REQ && I_TX_DONE |=> !O_TX_REQ)
    else $error("reply not released");
  a_poll_addr: assert property (I_RX_REMOTE_VALID && !O_TX_REQ && !I_RX_DATA_VALID
    && !$past(I_RX_DATA_VALID) |-> ##2 O_TX_REQ && O_TX_ADDR == ADDR_PORT_INPUT_STATE)
    else $error("poll reply wrong");
  a_pin_write: assert property (wr_pin |=> O_PIN == $past(val))
    else $error("output value not taken");
  a_pin_hold: assert property (!wr_pin |=> $stable(O_PIN))
    else $error("output value changed unasked");
  a_oe_write: assert property (wr_oe |=> O_PIN_OE == $past(val))
    else $error("driver enable not taken");
  a_pd_write: assert property (I_RX_DATA_VALID && I_RX_BYTE1 == ADDR_PULSE_DENSITY_ONE
    |=> O_PULSE_DENSITY_ONE == $past(pd_val))
    else $error("pulse density not taken");
  a_mux_write: assert property (I_RX_DATA_VALID && I_RX_BYTE1 == ADDR_ANALOG_SETUP
    |=> O_MUX_SEL == $past(mux_val))
    else $error("monitor mux not taken");
endmodule
bind clpr_reg_bank clpr_asserts i_clpr_asserts (
  .I_REF_CLK, .I_RST, .I_RX_DATA_VALID, .I_RX_BYTE1, .I_RX_BYTE2, .I_RX_BYTE3,
  .I_RX_REMOTE_VALID, .O_TX_REQ, .I_TX_DONE, .O_TX_ADDR, .O_PIN, .O_PIN_OE,
  .O_MUX_SEL, .O_PULSE_DENSITY_ONE
);
`default_nettype wire

// ===== clpr_host_model.sv
/*
  Host side of the CAN link: sends out each reply, promptly or slowly.
  Assumes the reply request stays high until the done pulse is taken.
*/
`default_nettype none
module clpr_host_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Reply offered by the bank
  input wire logic i_req,
  input wire logic i_slow,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_data,
  // Link progress
  output logic o_ctrl_done,
  output logic o_done,
  // Reply as received
  output logic o_got,
  output logic [7:0] o_got_addr,
  output logic [15:0] o_got_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_ctrl_done <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_ctrl_done <= i_req && !o_done && cnt == 1;
      o_done <= i_req && !o_done && cnt == (i_slow ? 24 : 4);
      cnt <= (i_req && !o_done) ? cnt + 1 : 0;
    end
  end
  // Reply content taken at the edge that sees done
  always_ff @(posedge i_clk) begin
    o_got <= i_req && o_done;
    o_got_addr <= i_addr;
    o_got_data <= i_data;
  end
endmodule
`default_nettype wire

// ===== clpr_reg_bank_tb.sv
/*
  Testbench of the CAN-linked port register bank with a host model.
  Assumes a 100 MHz clock and a reference model of the register contents.
*/
`default_nettype none
module clpr_reg_bank_tb
  import clpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rx_v, rem_v, cal, ctrl_done, tx_done, slow, got, conv_done, tx_req, cst;
  logic [7:0] b1, b2, b3, tx_addr, got_addr;
  logic [3:0] tx_st, st;
  logic [15:0] pin, tx_data, got_data, o_pin, o_oe, v, p;
  logic [2:0] cmp, mux, sw;
  logic [9:0] res, pd1, pd2;
  int n_mismatch, checked, n_got, n_cst, seed, k;
  int regs[9];
  clpr_reg_bank i_clpr_reg_bank (.I_REF_CLK(clk), .I_RST(rst), .I_RX_DATA_VALID(rx_v),
    .I_RX_BYTE1(b1), .I_RX_BYTE2(b2), .I_RX_BYTE3(b3), .I_RX_REMOTE_VALID(rem_v),
    .I_CALIBRATED(cal), .I_STATUS(st), .O_TX_REQ(tx_req), .I_TX_CTRL_DONE(ctrl_done),
    .I_TX_DONE(tx_done), .O_TX_STATUS(tx_st), .O_TX_ADDR(tx_addr), .O_TX_DATA(tx_data),
    .I_PIN(pin), .O_PIN(o_pin), .O_PIN_OE(o_oe), .I_CMP_OUT(cmp), .I_CONV_DONE(conv_done),
    .I_CONV_RESULT(res), .O_CONV_START(cst), .O_MUX_SEL(mux), .O_SWITCH_SEL(sw),
    .O_PULSE_DENSITY_ONE(pd1), .O_PULSE_DENSITY_TWO(pd2));
  clpr_host_model i_clpr_host_model (.i_clk(clk), .i_rst(rst), .i_req(tx_req), .i_slow(slow),
    .i_addr(tx_addr), .i_data(tx_data), .o_ctrl_done(ctrl_done), .o_done(tx_done),
    .o_got(got), .o_got_addr(got_addr), .o_got_data(got_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (got === 1'b1) n_got++;
    if (cst === 1'b1) n_cst++;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic frame(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    rx_v <= 1'b1;
    b1 <= a;
    {b2, b3} <= d;
    @(posedge clk);
    rx_v <= 1'b0;
  endtask
  task automatic reply(logic [7:0] a, logic [15:0] d);
    k = 0;
    while (got !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    check("reply", {15'h0, got}, 16'h1);
    check("reply addr", {8'h0, got_addr}, {8'h0, a});
    check("reply data", got_data, d);
    check("reply status", {12'h0, tx_st}, {12'h0, st});
    @(posedge clk);
  endtask
  function automatic logic [15:0] expd(int a);
    case (a)
      0: expd = pin;
      5: expd = {1'b0, cmp, 1'b0, regs[5][10:5], 5'h00};
      6, 7: expd = {regs[a][15:6], 6'h00};
      default: expd = regs[a][15:0];
    endcase
  endfunction
  task automatic finish_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    seed = 32'h4d80;
    {rx_v, rem_v, cal, slow, conv_done, b1, b2, b3, res, st} = '0;
    pin = 16'h00f0;
    cmp = 3'h0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cmp <= 3'($random(seed));
    st <= 4'($random(seed));
    @(posedge clk);
    check("req at reset", {15'h0, tx_req}, 16'h0);
    for (int a = 1; a < 8; a++) begin
      v = 16'($random(seed));
      if (a == 5) v[15] = 1'b0;
      regs[a] = v;
      frame(a[7:0], v);
      reply(a[7:0], expd(a));
    end
    check("pins", o_pin, regs[3][15:0]);
    check("drivers", o_oe, regs[4][15:0]);
    check("mux sw", {10'h0, mux, sw}, {10'h0, regs[5][10:5]});
    check("pd one", {pd1, 6'h0}, expd(6));
    check("pd two", {pd2, 6'h0}, expd(7));
    frame(ADDR_PORT_INPUT_STATE, 16'hffff);
    reply(ADDR_PORT_INPUT_STATE, pin);
    check("pins kept", o_pin, regs[3][15:0]);
    @(posedge clk);
    rem_v <= 1'b1;
    @(posedge clk);
    rem_v <= 1'b0;
    reply(ADDR_PORT_INPUT_STATE, pin);
    frame(ADDR_RISE_CAPTURE_ENABLE, 16'h0005);
    reply(ADDR_RISE_CAPTURE_ENABLE, 16'h0005);
    frame(ADDR_FALL_CAPTURE_ENABLE, 16'h0006);
    reply(ADDR_FALL_CAPTURE_ENABLE, 16'h0006);
    for (int i = 0; i < 7; i++) begin
      p = pin;
      p[i >> 1] = ~p[i >> 1];
      pin <= p;
      k = n_got;
      if (7'h39 >> i & 1) reply(ADDR_PORT_INPUT_STATE, p);
      else begin
        repeat (30) @(posedge clk);
        check("no event", 16'(n_got - k), 16'h0);
      end
    end
    slow <= 1'b1;
    p = pin;
    p[0] = 1'b1;
    pin <= p;
    repeat (8) @(posedge clk);
    p[8] = ~p[8];
    pin <= p;
    reply(ADDR_PORT_INPUT_STATE, p);
    slow <= 1'b0;
    cal <= 1'b1;
    reply(ADDR_PORT_INPUT_STATE, pin);
    frame(ADDR_ANALOG_SETUP, 16'h8000 | regs[5][15:0]);
    reply(ADDR_ANALOG_SETUP, expd(5) | 16'h8000);
    for (int j = 1; j < 3; j++) begin
      check("conv start", 16'(n_cst), 16'(j));
      res <= 10'($random(seed));
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      reply(ADDR_CONVERSION_RESULT, {6'h0, res});
      if (j == 1) begin
        frame(ADDR_CONVERSION_RESULT, 16'hffff);
        reply(ADDR_CONVERSION_RESULT, {6'h0, res});
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
